// ### bench/dispatch_rom_model.sv
// stand-in for the dispatch mapping ROMs on the datapath side
`timescale 1ns/1ps
`default_nettype none
module dispatch_rom_model (
  input wire logic [7:0] instruction_byte,
  output logic [7:0] opcode_rom_data,
  output logic [7:0] specifier_rom_data
);
  // distinct maps so a wrong ROM choice shows up
  assign opcode_rom_data = instruction_byte ^ 8'h5A;
  assign specifier_rom_data = {instruction_byte[3:0], instruction_byte[7:4]};
endmodule
`default_nettype wire

// ### bench/test_next_address_sequencer.sv
// self-checking bench for the next-address sequencer
`timescale 1ns/1ps
`default_nettype none
module test_next_address_sequencer;
  typedef struct packed {
    logic [14:0] nab;
    logic [6:0] ctl;
    logic [6:0] msk;
    logic [3:0] sp;
    logic pg;
  } note_t;
  logic ref_clk = 0;
  logic rst_n = 0;
  logic [18:0] csw = 0;
  logic [4:0] sc = 5'h15;
  logic [3:0] jc = 0;
  logic jm = 0, ds = 0, scond = 0, jcond = 0, ib = 0, err = 0, pset = 0, pclr = 0;
  logic [4:0] spec_bits = 0;
  logic [7:0] ibyte = 0;
  logic b_scond = 0, b_jcond = 0, b_ib = 0, b_err = 0, b_pset = 0, b_pclr = 0;
  logic [4:0] b_spec = 0;
  logic [7:0] b_byte = 0;
  wire [7:0] opc, spc;
  wire [14:0] nab;
  wire [3:0] sp_o;
  wire [6:0] ctl_o;
  wire pg_o, mstart, strobe;
  logic [14:0] upc = 0;
  logic [14:0] stk [16];
  logic [3:0] msp = 0;
  logic mpg = 0;
  note_t q[$];
  note_t pend;
  logic has_pend = 0;
  int fails = 0;
  int check_count = 0;
  logic [15:0] rnd = 16'h9347;

  // free-running bench clock
  always #4 ref_clk = ~ref_clk;

  dispatch_rom_model roms (.instruction_byte(ibyte), .opcode_rom_data(opc),
    .specifier_rom_data(spc));

  next_address_sequencer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .control_store_word(csw),
    .skip_control_field(sc), .jump_control_field(jc), .jump_microinstruction(jm),
    .dispatch_microinstruction(ds), .skip_condition(scond), .jump_condition(jcond),
    .instruction_byte_available(ib), .error_summary(err),
    .operand_specifier_register(spec_bits),
    .opcode_rom_data(opc), .specifier_rom_data(spc), .page_set(pset), .page_clear(pclr),
    .next_address_bus(nab), .microcycle_start(mstart), .register_clock_strobe(strobe),
    .micro_pc_drive(ctl_o[6]), .return_drive(ctl_o[5]), .incrementer_carry_in(ctl_o[4]),
    .stack_pointer_count(ctl_o[3]), .high_jump_select(ctl_o[2]),
    .low_jump_select(ctl_o[1]), .dispatch_rom_select(ctl_o[0]),
    .user_store_page_flag(pg_o), .stack_pointer(sp_o));

  function automatic logic [18:0] jw(input logic [13:0] t, input logic o, input logic dir);
    return {o, t, dir, 3'b000};
  endfunction

  function automatic logic [14:0] inc(input logic [14:0] a, input logic c);
    return {a[14:11], a[10:0] + 11'(c)};
  endfunction

  // 16-bit feedback shift register for the random tests
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for the edge that captures a microinstruction
  task automatic wait_cap();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (mstart !== 1'b1 && n < 16);
    if (mstart !== 1'b1) begin
      fails++;
      test_done();
    end
  endtask

  // reference model: next address, control levels, stack and page
  task automatic model(input logic [18:0] w, input logic [4:0] s, input logic [3:0] j,
    input logic m, input logic d);
    logic [14:0] na;
    logic [6:0] c, mk;
    logic tk, call, r, cin, spc_n;
    mk = 7'h7F;
    if (m || d) begin
      call = j == 4'hC || (j == 4'hD && b_ib);
      tk = call || j == 4'h4 || (b_jcond && j != 4'hC && j != 4'hD && j != 4'hE);
      if (tk) begin
        na = d ? {mpg, w[17:12], (w[4] ? b_byte ^ 8'h5A : {b_byte[3:0], b_byte[7:4]})}
          : {mpg, w[17:9], w[8:4] | (w[18] ? b_spec : 5'h00)};
        c = {3'b000, call, 1'b1, m, d};
        mk = 7'h3F;
        if (call) begin
          msp = msp - 4'h1;
          stk[msp] = upc;
        end
      end else begin
        cin = j == 4'hE && b_ib;
        na = inc(upc, cin);
        c = {1'b1, 1'b0, cin, 4'h0};
      end
    end else begin
      r = 0;
      cin = 0;
      spc_n = 0;
      case (s)
        5'h15: ;
        5'h1E: cin = 1;
        5'h14: {r, spc_n} = 2'b11;
        5'h16: {r, spc_n, cin} = 3'b111;
        5'h10: {r, spc_n, cin} = {!b_err, !b_err, 1'b1};
        5'h11, 5'h13: {r, spc_n} = {b_scond, !b_scond};
        5'h12: spc_n = 1;
        5'h17: r = b_scond;
        default: cin = b_scond;
      endcase
      na = inc(r ? stk[msp] : upc, cin);
      c = {!r, r, cin, spc_n, 3'b000};
      if (spc_n) msp = msp + 4'h1;
    end
    mpg = b_pset ? 1'b1 : b_pclr ? 1'b0 : mpg;
    upc = na + 15'h0001;
    pend = {na, c, mk, msp, mpg};
    has_pend = 1;
  endtask

  // present one microinstruction and note what it should produce
  task automatic step(input logic [18:0] w, input logic [4:0] s, input logic [3:0] j,
    input logic m, input logic d);
    wait_cap();
    if (has_pend) q.push_back(pend);
    model(w, s, j, m, d);
    csw <= w;
    sc <= s;
    jc <= j;
    jm <= m;
    ds <= d;
    scond <= b_scond;
    jcond <= b_jcond;
    ib <= b_ib;
    err <= b_err;
    pset <= b_pset;
    pclr <= b_pclr;
    spec_bits <= b_spec;
    ibyte <= b_byte;
  endtask

  // watcher: compare each captured microinstruction against its note
  initial begin
    note_t e;
    forever begin
      wait_cap();
      #1;
      if (q.size() > 0) begin
        e = q.pop_front();
        chk(strobe, 1'b1);
        repeat (3) @(posedge ref_clk);
        chk(nab, e.nab);
        chk(ctl_o & e.msk, e.ctl & e.msk);
        #1;
        chk(sp_o, e.sp);
        chk(pg_o, e.pg);
      end
    end
  end

  // main sequence
  initial begin
    logic [4:0] s;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1;
    step(jw(14'h07FE, 0, 0), 5'h15, 4'h4, 1, 0);
    step(jw(0, 0, 0), 5'h1E, 4'h0, 0, 0);
    step(jw(0, 0, 0), 5'h15, 4'h4, 0, 0);
    b_pset = 1;
    step(jw(0, 0, 0), 5'h1E, 4'h1, 1, 0);
    b_pset = 0;
    b_spec = 5'h15;
    step(jw(14'h0123, 1, 0), 5'h15, 4'h4, 1, 0);
    b_ib = 1;
    step(jw(0, 0, 0), 5'h00, 4'hE, 1, 0);
    b_byte = 8'hC3;
    step(jw(14'h0301, 0, 0), 5'h15, 4'h4, 0, 1);
    b_pclr = 1;
    step(jw(14'h0300, 0, 0), 5'h15, 4'h4, 0, 1);
    b_pclr = 0;
    $display("test jumps done");
    step(jw(14'h0200, 0, 0), 5'h15, 4'hC, 1, 0);
    b_ib = 0;
    step(jw(14'h0250, 0, 0), 5'h15, 4'hD, 1, 0);
    b_ib = 1;
    step(jw(14'h0250, 0, 0), 5'h15, 4'hD, 1, 0);
    step(jw(0, 0, 1), 5'h14, 4'h4, 0, 0);
    step(jw(0, 0, 1), 5'h16, 4'h0, 0, 0);
    step(jw(14'h0400, 0, 0), 5'h15, 4'hC, 1, 0);
    b_err = 1;
    step(jw(0, 0, 1), 5'h10, 4'h0, 0, 0);
    b_err = 0;
    step(jw(0, 0, 1), 5'h10, 4'h0, 0, 0);
    step(jw(14'h0500, 0, 0), 5'h15, 4'hC, 1, 0);
    b_scond = 1;
    for (int i = 0; i < 4; i++) step(jw(0, 0, 1), 5'h11 + 5'(2 * i), 4'h0, 0, 0);
    b_scond = 0;
    step(jw(0, 0, 1), 5'h17, 4'h0, 0, 0);
    step(jw(0, 0, 1), 5'h11, 4'h0, 0, 0);
    step(jw(0, 0, 1), 5'h12, 4'h0, 0, 0);
    $display("test stack done");
    repeat (40) begin
      rnd = lfsr(rnd);
      {b_scond, b_jcond, b_ib, b_spec, b_byte} = {rnd[0], rnd[1], rnd[7], rnd[6:2], rnd[15:8]};
      s = rnd[13] ? {3'b110, rnd[10:9]} : {1'b0, rnd[12:9]};
      step(jw({4'h0, rnd[9:0]}, rnd[14], 0), s, rnd[12:9], rnd[3] & ~rnd[4], rnd[3] & rnd[4]);
    end
    step(jw(0, 0, 0), 5'h15, 4'h0, 0, 0);
    for (int i = 0; i < 40 && q.size() > 0; i++) @(posedge ref_clk);
    if (q.size() > 0) fails++;
    repeat (6) @(posedge ref_clk);
    $display("test random done");
    test_done();
  end
endmodule
`default_nettype wire

// ### verilog/low_incrementer.sv
// 11-bit incrementer between the micro-pc bus and the next-address bus
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_defs.svh"
module low_incrementer (
  input wire logic [`LOW_W-1:0] value,
  input wire logic carry_in,
  output logic [`LOW_W-1:0] sum
);
  // carry out is dropped so steps stay inside the page
  assign sum = value + {10'h000, carry_in};
endmodule
`default_nettype wire

// ### verilog/next_address_sequencer.sv
// next-microaddress sequencer with subroutine stack and page flag
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_defs.svh"
module next_address_sequencer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [18:0] control_store_word,
  input wire logic [4:0] skip_control_field,
  input wire logic [3:0] jump_control_field,
  input wire logic jump_microinstruction,
  input wire logic dispatch_microinstruction,
  input wire logic skip_condition,
  input wire logic jump_condition,
  input wire logic instruction_byte_available,
  input wire logic error_summary,
  input wire logic [4:0] operand_specifier_register,
  input wire logic [7:0] opcode_rom_data,
  input wire logic [7:0] specifier_rom_data,
  input wire logic page_set,
  input wire logic page_clear,
  output logic [`ADDR_W-1:0] next_address_bus,
  output logic microcycle_start,
  output logic register_clock_strobe,
  output logic micro_pc_drive,
  output logic return_drive,
  output logic incrementer_carry_in,
  output logic stack_pointer_count,
  output logic high_jump_select,
  output logic low_jump_select,
  output logic dispatch_rom_select,
  output logic user_store_page_flag,
  output logic [`SP_W-1:0] stack_pointer
);
  // captured microinstruction and conditions
  sequencer_pkg::phase_t phase, next_phase;
  logic [18:0] word, next_word;
  logic [4:0] sfield, next_sfield;
  logic [3:0] jfield, next_jfield;
  logic jump_inst, next_jump_inst;
  logic disp_inst, next_disp_inst;
  logic s_cond, next_s_cond;
  logic j_cond, next_j_cond;
  logic ib_ok, next_ib_ok;
  logic err, next_err;
  logic [4:0] spec, next_spec;
  logic [7:0] opc_rom, next_opc_rom;
  logic [7:0] spec_rom, next_spec_rom;
  logic set_page, next_set_page;
  logic clr_page, next_clr_page;
  // address, stack and page state
  logic [`ADDR_W-1:0] micro_pc, next_micro_pc, next_next_address;
  logic [`SP_W-1:0] next_stack_pointer;
  logic next_user_store_page_flag;
  // decode and datapath nets
  logic jump_taken, push, count_up;
  logic [`ADDR_W-1:0] micro_pc_bus, top_of_stack;
  logic [`LOW_W-1:0] low_sum;
  logic [`SP_W-1:0] write_addr;
  logic [4:0] low_jump;
  always_comb begin
    next_word = word;
    next_sfield = sfield;
    next_jfield = jfield;
    next_jump_inst = jump_inst;
    next_disp_inst = disp_inst;
    next_s_cond = s_cond;
    next_j_cond = j_cond;
    next_ib_ok = ib_ok;
    next_err = err;
    next_spec = spec;
    next_opc_rom = opc_rom;
    next_spec_rom = spec_rom;
    next_set_page = set_page;
    next_clr_page = clr_page;
    case (phase)
      sequencer_pkg::PH_SAMPLE: begin
        next_phase = sequencer_pkg::PH_STROBE;
        next_word = control_store_word;
        next_sfield = skip_control_field;
        next_jfield = jump_control_field;
        next_jump_inst = jump_microinstruction;
        next_disp_inst = dispatch_microinstruction;
        next_s_cond = skip_condition;
        next_j_cond = jump_condition;
        next_ib_ok = instruction_byte_available;
        next_err = error_summary;
        next_spec = operand_specifier_register;
        next_opc_rom = opcode_rom_data;
        next_spec_rom = specifier_rom_data;
        next_set_page = page_set;
        next_clr_page = page_clear;
      end
      sequencer_pkg::PH_STROBE: next_phase = sequencer_pkg::PH_SETTLE;
      sequencer_pkg::PH_SETTLE: next_phase = sequencer_pkg::PH_PRESENT;
      sequencer_pkg::PH_PRESENT: next_phase = sequencer_pkg::PH_SAMPLE;
      default: next_phase = sequencer_pkg::PH_SAMPLE;
    endcase
    if (!rst_n) begin
      next_phase = sequencer_pkg::PH_SAMPLE;
      next_word = 19'h0_0000;
      next_sfield = `SC_NOP;
      next_jfield = 4'h0;
      next_jump_inst = 1'b0;
      next_disp_inst = 1'b0;
      next_set_page = 1'b0;
      next_clr_page = 1'b0;
    end
  end

  // phase and capture registers
  always_ff @(posedge ref_clk) begin
    phase <= next_phase;
    word <= next_word;
    sfield <= next_sfield;
    jfield <= next_jfield;
    jump_inst <= next_jump_inst;
    disp_inst <= next_disp_inst;
    s_cond <= next_s_cond;
    j_cond <= next_j_cond;
    ib_ok <= next_ib_ok;
    err <= next_err;
    spec <= next_spec;
    opc_rom <= next_opc_rom;
    spec_rom <= next_spec_rom;
    set_page <= next_set_page;
    clr_page <= next_clr_page;
  end
  // microcycle framing strobes
  assign microcycle_start = (phase == sequencer_pkg::PH_SAMPLE);
  assign register_clock_strobe = (phase == sequencer_pkg::PH_STROBE);
  // control decode of skip and jump fields
  always_comb begin
    micro_pc_drive = 1'b0;
    return_drive = 1'b0;
    stack_pointer_count = 1'b0;
    incrementer_carry_in = 1'b0;
    jump_taken = 1'b0;
    push = 1'b0;
    if (jump_inst || disp_inst) begin
      micro_pc_drive = 1'b1;
      case (jfield)
        `JC_JUMP, `JC_CALL: jump_taken = 1'b1;
        `JC_CALL_IB: jump_taken = ib_ok;
        `JC_SKIP_IB: incrementer_carry_in = ib_ok;
        default: jump_taken = j_cond;
      endcase
      push = jump_taken && (jfield == `JC_CALL || jfield == `JC_CALL_IB);
      stack_pointer_count = push;
    end else begin
      case (sfield)
        `SC_NOP: micro_pc_drive = 1'b1;
        `SC_SKIP: begin
          micro_pc_drive = 1'b1;
          incrementer_carry_in = 1'b1;
        end
        `SC_RETURN: begin
          return_drive = 1'b1;
          stack_pointer_count = 1'b1;
        end
        `SC_RET_P1: begin
          return_drive = 1'b1;
          stack_pointer_count = 1'b1;
          incrementer_carry_in = 1'b1;
        end
        `SC_RET_P1_COND: begin
          incrementer_carry_in = 1'b1;
          return_drive = !err;
          stack_pointer_count = !err;
          micro_pc_drive = err;
        end
        `SC_LOOP_Z, `SC_LOOP_C: begin
          return_drive = s_cond;
          micro_pc_drive = !s_cond;
          stack_pointer_count = !s_cond;
        end
        `SC_LOOP_SYNC: begin
          return_drive = s_cond;
          micro_pc_drive = !s_cond;
        end
        `SC_POP: begin
          micro_pc_drive = 1'b1;
          stack_pointer_count = 1'b1;
        end
        default: begin
          micro_pc_drive = 1'b1;
          incrementer_carry_in = s_cond;
        end
      endcase
    end
  end

  assign high_jump_select = jump_taken;
  assign low_jump_select = jump_taken && jump_inst;
  assign dispatch_rom_select = jump_taken && disp_inst;
  // returns put top of stack on the micro-pc bus
  assign micro_pc_bus = return_drive ? top_of_stack : (micro_pc_drive ? micro_pc : `RST_ADDR);
  // only the low bits are incremented
  low_incrementer u_inc (
    .value(micro_pc_bus[`LOW_W-1:0]),
    .carry_in(incrementer_carry_in),
    .sum(low_sum)
  );
  // specifier bits ORed under word bit 18
  assign low_jump = word[`CSW_LO_MSB:`CSW_LO_LSB] |
    (word[`CSW_OS_SEL] ? spec : 5'h00);
  // next address selection
  always_comb begin
    // high bits pass, low bits incremented
    next_next_address = {micro_pc_bus[14:11], low_sum};
    if (jump_taken) begin
      // page flag and jump field on high bits
      next_next_address[14:5] = {user_store_page_flag, word[`CSW_HI_MSB:`CSW_HI_LSB]};
      // low jump field on jump words
      if (jump_inst) begin
        next_next_address[4:0] = low_jump;
      end
      if (disp_inst) begin
        next_next_address[7:0] = word[`CSW_ROM_SEL] ? opc_rom : spec_rom;
      end
    end
    if (phase != sequencer_pkg::PH_STROBE) begin
      next_next_address = next_address_bus;
    end
    // micro-pc holds presented address plus one
    next_micro_pc = micro_pc;
    if (phase == sequencer_pkg::PH_PRESENT) begin
      next_micro_pc = next_address_bus + 15'h0001;
    end
    if (!rst_n) begin
      next_next_address = `RST_ADDR;
      next_micro_pc = `RST_ADDR;
    end
  end

  // address registers
  always_ff @(posedge ref_clk) begin
    next_address_bus <= next_next_address;
    micro_pc <= next_micro_pc;
  end
  // write address pre-decremented for a push when word bit 3 is clear, else the pointer itself
  assign count_up = word[`CSW_SP_DIR];
  assign write_addr = count_up ? stack_pointer : stack_pointer - `SP_STEP;
  // push at the strobe trailing edge
  subroutine_stack u_stack (
    .ref_clk(ref_clk),
    .write_en(push && register_clock_strobe),
    .write_addr(write_addr),
    .write_data(micro_pc_bus),
    .read_addr(stack_pointer),
    .read_data(top_of_stack)
  );
  // pointer and page flag next values
  always_comb begin
    next_stack_pointer = stack_pointer;
    next_user_store_page_flag = user_store_page_flag;
    if (phase == sequencer_pkg::PH_SETTLE) begin
      if (stack_pointer_count) begin
        next_stack_pointer = count_up ? stack_pointer + `SP_STEP : stack_pointer - `SP_STEP;
      end
      if (set_page) begin
        next_user_store_page_flag = 1'b1;
      end else if (clr_page) begin
        next_user_store_page_flag = 1'b0;
      end
    end
    if (!rst_n) begin
      next_stack_pointer = `RST_SP;
      next_user_store_page_flag = 1'b0;
    end
  end

  // pointer and page registers
  always_ff @(posedge ref_clk) begin
    stack_pointer <= next_stack_pointer;
    user_store_page_flag <= next_user_store_page_flag;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_skip_plus_two: assert property (
    register_clock_strobe && micro_pc_drive && incrementer_carry_in && !jump_taken
    |=> next_address_bus == {$past(micro_pc[14:11]), $past(micro_pc[10:0]) + 11'h001})
    else $error("skip did not give micro-pc plus one");
  a_nop_sequential: assert property (
    register_clock_strobe && micro_pc_drive && !incrementer_carry_in && !jump_taken
    |=> next_address_bus == $past(micro_pc))
    else $error("no-op did not keep micro-pc");
  a_jump_high_bits: assert property (
    register_clock_strobe && jump_taken
    |=> next_address_bus[14:8] == {$past(user_store_page_flag), $past(word[17:12])})
    else $error("taken jump high bits wrong");
  a_jump_low_bits: assert property (
    register_clock_strobe && jump_taken && jump_inst
    |=> next_address_bus[4:0] == ($past(word[8:4]) | ($past(word[18]) ? $past(spec) : 5'h00)))
    else $error("jump low bits wrong");
  a_dispatch_byte: assert property (
    register_clock_strobe && jump_taken && disp_inst
    |=> next_address_bus[7:0] == ($past(word[4]) ? $past(opc_rom) : $past(spec_rom)))
    else $error("dispatch low byte wrong");
  a_call_pointer: assert property (
    register_clock_strobe && push |-> ##2 stack_pointer == $past(stack_pointer, 2) - `SP_STEP)
    else $error("call did not count pointer down");
  a_return_pointer: assert property (
    register_clock_strobe && sfield == `SC_RETURN && !jump_inst && !disp_inst
    |=> next_address_bus == $past(top_of_stack) ##1 stack_pointer == $past(stack_pointer) + `SP_STEP)
    else $error("return address or pointer wrong");
  a_loop_keeps_pointer: assert property (
    register_clock_strobe && return_drive && !stack_pointer_count
    |-> ##3 stack_pointer == $past(stack_pointer, 3))
    else $error("loop moved the stack pointer");
  a_page_stays: assert property (
    register_clock_strobe && !jump_taken
    |=> next_address_bus[14:11] == $past(micro_pc_bus[14:11]))
    else $error("increment crossed a page");
  a_microcycle_length: assert property (
    microcycle_start |=> !microcycle_start [*3] ##1 microcycle_start)
    else $error("microcycle is not four clocks");
endmodule
`default_nettype wire

// ### verilog/sequencer_defs.svh
// constants for the next-address sequencer
`ifndef SEQUENCER_DEFS_SVH
`define SEQUENCER_DEFS_SVH
// widths and stack depth
`define ADDR_W 15
`define LOW_W 11
`define STACK_DEPTH 16
`define SP_W 4
`define SP_STEP 4'h1
// reset values
`define RST_ADDR 15'h0000
`define RST_SP 4'h0
// timing: clock edges per microcycle at 125 MHz
`define CLK_PERIOD_NS 8
`define MICROCYCLE_NS 32
`define MICROCYCLE_CLOCKS (`MICROCYCLE_NS / `CLK_PERIOD_NS)
// control store word field positions
`define CSW_OS_SEL 18
`define CSW_HI_MSB 17
`define CSW_HI_LSB 9
`define CSW_LO_MSB 8
`define CSW_LO_LSB 4
`define CSW_ROM_SEL 4
`define CSW_SP_DIR 3
// skip control codes
`define SC_RET_P1_COND 5'h10
`define SC_LOOP_Z 5'h11
`define SC_POP 5'h12
`define SC_LOOP_C 5'h13
`define SC_RETURN 5'h14
`define SC_NOP 5'h15
`define SC_RET_P1 5'h16
`define SC_LOOP_SYNC 5'h17
`define SC_SKIP 5'h1E
// jump control codes
`define JC_JUMP 4'h4
`define JC_CALL 4'hC
`define JC_CALL_IB 4'hD
`define JC_SKIP_IB 4'hE
`endif

// ### verilog/sequencer_pkg.sv
// types of the next-address sequencer
`default_nettype none
package sequencer_pkg;
  // microcycle phases, gray coded along the cycle
  typedef enum logic [1:0] {
    PH_SAMPLE = 2'b00,
    PH_STROBE = 2'b01,
    PH_SETTLE = 2'b11,
    PH_PRESENT = 2'b10
  } phase_t;
endpackage
`default_nettype wire

// ### verilog/subroutine_stack.sv
// subroutine stack memory with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_defs.svh"
module subroutine_stack (
  input wire logic ref_clk,
  input wire logic write_en,
  input wire logic [`SP_W-1:0] write_addr,
  input wire logic [`ADDR_W-1:0] write_data,
  input wire logic [`SP_W-1:0] read_addr,
  output logic [`ADDR_W-1:0] read_data
);
  logic [`ADDR_W-1:0] mem [0:`STACK_DEPTH-1];

  // write port and registered read port
  always_ff @(posedge ref_clk) begin
    if (write_en) begin
      mem[write_addr] <= write_data;
    end
    read_data <= mem[read_addr];
  end
endmodule
`default_nettype wire
